// ==== core/dnto_core.sv ====
// Command decode, temperature status and termination control with an AXI4-Lite register slave.
// Assumes the device state flags come from the device's main state machine on the same clock.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dnto_core #(
  parameter int unsigned P_TSI_CYC  = dnto_pkg::TSI_CYC_DEF,
  parameter bit          P_HAS_ODT  = 1'b1
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  input  wire dnto_pkg::dnto_cmd_s    i_cmd,
  input  wire logic [7:0]             i_mr_addr,
  input  wire logic                   i_self_refresh,
  input  wire logic                   i_power_down,
  input  wire logic                   i_deep_pd,
  input  wire logic                   i_ca_training,
  input  wire logic [2:0]             i_sensor_code,
  input  wire logic                   i_term_pin,
  output logic                        o_nop,
  output logic                        o_read_busy,
  output logic                        o_mrr_valid,
  output logic [7:0]                  o_mrr_data,
  output logic                        o_term_dq_en,
  output logic                        o_term_dqs_en,
  output logic                        o_term_dm_en,
  output logic [1:0]                  o_term_rtt_sel,
  output logic                        o_irq,
  input  wire logic [7:0]             i_awaddr,
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  output logic [1:0]                  o_bresp,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  input  wire logic [7:0]             i_araddr,
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  output logic                        o_rvalid,
  input  wire logic                   i_rready
);
  import dnto_pkg::*;

  // Register map decode shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == REG_IRQ_STATUS) || (a == REG_IRQ_CLEAR) || (a == REG_IRQ_ENABLE) ||
                  (a == REG_TERM_MODE) || (a == REG_TEMP_STAT) || (a == REG_NOP_COUNT) ||
                  (a == REG_STATE);
  endfunction

  logic              cke_prev_q;
  logic              cmd_sel;
  logic              cmd_nop;
  logic              cmd_read;
  logic              cmd_mrr;
  dnto_rd_e          rd_state_q;
  logic [4:0]        rd_cnt_q;
  logic [2:0]        term_mode_q;
  logic [2:0]        temp_q;
  logic [2:0]        sensor_prev_q;
  logic [31:0]       tsi_cnt_q;
  logic              lp_prev_q;
  logic              temp_load;
  logic              term_allow_q;
  logic [31:0]       nop_cnt_q;
  logic [EV_W-1:0]   ev_status_q;
  logic [EV_W-1:0]   ev_enable_q;
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   ev_clr;
  logic              aw_have_q;
  logic              w_have_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_go;
  logic [31:0]       rd_word;

  // Command decode at the rising edge
  assign cmd_sel  = i_cmd.cke && !i_cmd.cs_n;
  assign cmd_nop  = i_cmd.cs_n || (i_cmd.ca[2:0] == CA_NOP);
  assign cmd_read = cmd_sel && (i_cmd.ca[2:0] == CA_READ);
  assign cmd_mrr  = cmd_sel && (i_cmd.ca == CA_MRR);

  // Previous clock enable level
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      cke_prev_q <= 1'b1;
    else
      cke_prev_q <= i_cmd.cke;
  end

  // No-op pulse and counter
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_nop     <= 1'b0;
      nop_cnt_q <= 32'h00000000;
    end
    else
    begin
      o_nop <= cmd_nop && i_cmd.cke;
      if (cmd_nop && i_cmd.cke)
        nop_cnt_q <= nop_cnt_q + 32'h00000001;
    end
  end

  // Read burst tracker; a no-op never touches it
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      rd_state_q <= RD_IDLE;
      rd_cnt_q   <= 5'h00;
    end
    else
    begin
      case (rd_state_q)
        RD_IDLE:
        begin
          if (cmd_read || cmd_mrr)
          begin
            rd_state_q <= RD_BUSY;
            rd_cnt_q   <= READ_BUSY_CYC;
          end
        end
        RD_BUSY:
        begin
          if (cmd_read || cmd_mrr)
            rd_cnt_q <= READ_BUSY_CYC;
          else if (rd_cnt_q == 5'h01)
            rd_state_q <= RD_IDLE;
          else
            rd_cnt_q <= rd_cnt_q - 5'h01;
        end
        default:
          rd_state_q <= RD_IDLE;
      endcase
    end
  end

  assign temp_load = (tsi_cnt_q >= P_TSI_CYC - 1) ||
                     (lp_prev_q && !(i_self_refresh || i_power_down)) ||
                     (i_sensor_code != sensor_prev_q);

  // Temperature status refresh
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      temp_q        <= TEMP_RST;
      sensor_prev_q <= TEMP_RST;
      tsi_cnt_q     <= 32'h00000000;
      lp_prev_q     <= 1'b0;
    end
    else
    begin
      sensor_prev_q <= i_sensor_code;
      lp_prev_q     <= i_self_refresh || i_power_down;
      if (temp_load)
      begin
        temp_q    <= i_sensor_code;
        tsi_cnt_q <= 32'h00000000;
      end
      else
        tsi_cnt_q <= tsi_cnt_q + 32'h00000001;
    end
  end

  // Mode register read answer
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_mrr_valid <= 1'b0;
      o_mrr_data  <= 8'h00;
    end
    else
    begin
      o_mrr_valid <= cmd_mrr;
      if (cmd_mrr && i_mr_addr == MR_ADDR_TEMP)
        o_mrr_data <= {5'h00, temp_q};
      else if (cmd_mrr && i_mr_addr == MR_ADDR_TERM)
        o_mrr_data <= {5'h00, term_mode_q};
      else if (cmd_mrr)
        o_mrr_data <= 8'h00;
    end
  end

  // Termination permission from mode and operating state
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      term_allow_q <= 1'b0;
    else
      term_allow_q <= P_HAS_ODT
                      && (term_mode_q[TM_RTT_LSB +: 2] != 2'h0)
                      && !i_self_refresh && !i_deep_pd
                      && !(i_power_down && !term_mode_q[TM_PD_EN])
                      && !(cmd_read || cmd_mrr) && (rd_state_q != RD_BUSY || rd_cnt_q == 5'h01)
                      && !i_ca_training;
  end

  // Pin gates the enables directly, no clock sampling
  always_comb
  begin
    o_term_dq_en  = i_term_pin && term_allow_q;
    o_term_dqs_en = i_term_pin && term_allow_q;
    o_term_dm_en  = i_term_pin && term_allow_q;
  end

  // Resistance select follows the mode bits
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_term_rtt_sel <= 2'h0;
    else
      o_term_rtt_sel <= P_HAS_ODT ? term_mode_q[TM_RTT_LSB +: 2] : 2'h0;
  end

  // Read busy flag for the outside
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_read_busy <= 1'b0;
    else
      o_read_busy <= (rd_state_q == RD_BUSY);
  end

  // Events: bad no-op timing, refresh, elevated range, code change
  always_comb
  begin
    ev_set              = '0;
    ev_set[EV_BAD_NOP]  = cmd_nop && !i_cmd.cs_n && (i_cmd.cke != cke_prev_q);
    ev_set[EV_TEMP_UPD] = temp_load;
    ev_set[EV_ELEVATED] = temp_load && (i_sensor_code == TEMP_ELEVATED);
    ev_set[EV_TEMP_CHG] = temp_load && (i_sensor_code != temp_q);
  end

  // Sticky status; set wins over clear
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      ev_status_q <= '0;
    else
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
  end

  // Level interrupt
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(((ev_status_q & ~ev_clr) | ev_set) & ev_enable_q);
  end

  // AXI write address and data capture, either order
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end
    else
    begin
      o_awready <= !aw_have_q && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready  <= !w_have_q && !(i_wvalid && o_wready) && !o_bvalid;
      if (i_awvalid && o_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
      if (i_wvalid && o_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  assign wr_go  = aw_have_q && w_have_q && !o_bvalid;
  assign ev_clr = (wr_go && aw_addr_q == REG_IRQ_CLEAR && w_strb_q[0]) ? w_data_q[EV_W-1:0] : '0;

  // Register writes and write response
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      term_mode_q <= TERM_MODE_RST;
      ev_enable_q <= '0;
      o_bvalid    <= 1'b0;
      o_bresp     <= AXI_OKAY;
    end
    else
    begin
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= addr_mapped(aw_addr_q) ? AXI_OKAY : AXI_SLVERR;
        if (aw_addr_q == REG_TERM_MODE && w_strb_q[0])
          term_mode_q <= w_data_q[2:0];
        if (aw_addr_q == REG_IRQ_ENABLE && w_strb_q[0])
          ev_enable_q <= w_data_q[EV_W-1:0];
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // Read data mux
  always_comb
  begin
    case (i_araddr)
      REG_IRQ_STATUS: rd_word = {28'h0000000, ev_status_q};
      REG_IRQ_ENABLE: rd_word = {28'h0000000, ev_enable_q};
      REG_TERM_MODE:  rd_word = {29'h0, term_mode_q};
      REG_TEMP_STAT:  rd_word = {29'h0, temp_q};
      REG_NOP_COUNT:  rd_word = nop_cnt_q;
      REG_STATE:      rd_word = {30'h0, term_allow_q, rd_state_q == RD_BUSY};
      default:        rd_word = 32'h00000000;
    endcase
  end

  // AXI read channel
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= AXI_OKAY;
    end
    else
    begin
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready)
      begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_word;
        o_rresp  <= addr_mapped(i_araddr) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== core/dnto_pkg.sv ====
// Constants, types and register map for the command decode, temperature status and termination control block.
// Assumes a single 50 MHz clock with a synchronous active-low reset and an AXI4-Lite register bus.
package dnto_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_CLEAR  = 8'h04;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] REG_TERM_MODE  = 8'h0C;
  localparam logic [7:0] REG_TEMP_STAT  = 8'h10;
  localparam logic [7:0] REG_NOP_COUNT  = 8'h14;
  localparam logic [7:0] REG_STATE      = 8'h18;

  // Interrupt event bit positions
  localparam int EV_BAD_NOP   = 0;
  localparam int EV_TEMP_UPD  = 1;
  localparam int EV_ELEVATED  = 2;
  localparam int EV_TEMP_CHG  = 3;
  localparam int EV_W         = 4;

  // Termination mode register fields and reset value
  localparam int TM_RTT_LSB   = 0;
  localparam int TM_PD_EN     = 2;
  localparam logic [2:0] TERM_MODE_RST = 3'h0;

  // Temperature status fields
  localparam logic [2:0] TEMP_ELEVATED = 3'h3;
  localparam logic [2:0] TEMP_RST      = 3'h0;
  localparam logic [7:0] MR_ADDR_TEMP  = 8'h04;
  localparam logic [7:0] MR_ADDR_TERM  = 8'h0B;

  // Command encodings with chip select low: no-op and read on CA[2:0], MRR on CA[3:0]
  localparam logic [2:0] CA_NOP   = 3'h7;
  localparam logic [2:0] CA_READ  = 3'h5;
  localparam logic [3:0] CA_MRR   = 4'h8;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Timing: sensor interval and read busy window
  localparam int TSI_MS        = 32;
  localparam int CLK_KHZ       = 50000;
  localparam int TSI_CYC_DEF   = TSI_MS * CLK_KHZ;
  localparam logic [4:0] READ_BUSY_CYC = 5'h10;

  // Command pins sampled on the rising clock edge
  typedef struct packed {
    logic       cke;
    logic       cs_n;
    logic [3:0] ca;
  } dnto_cmd_s;

  // Read burst tracker
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_BUSY = 2'b10
  } dnto_rd_e;

endpackage

// ==== tb/dnto_core_assertions.sv ====
// Checker for command decode, read window, termination gating and bus answer timing of dnto_core.
// Sees only the top module's ports; bound to every dnto_core at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module dnto_core_assertions #(
  parameter int unsigned P_TSI_CYC = 50,
  parameter bit          P_HAS_ODT = 1'b1
) (
  input wire logic                i_ref_clk,
  input wire logic                i_rst_n,
  input wire dnto_pkg::dnto_cmd_s i_cmd,
  input wire logic                i_self_refresh,
  input wire logic                i_deep_pd,
  input wire logic                i_ca_training,
  input wire logic                i_term_pin,
  input wire logic                o_nop,
  input wire logic                o_read_busy,
  input wire logic                o_mrr_valid,
  input wire logic [7:0]          o_mrr_data,
  input wire logic                o_term_dq_en,
  input wire logic                o_term_dqs_en,
  input wire logic                o_term_dm_en,
  input wire logic [1:0]          o_term_rtt_sel,
  input wire logic                o_irq,
  input wire logic                i_awvalid,
  input wire logic                o_awready,
  input wire logic                i_wvalid,
  input wire logic                o_wready,
  input wire logic                o_bvalid,
  input wire logic                i_arvalid,
  input wire logic                o_arready,
  input wire logic                o_rvalid
);
  import dnto_pkg::*;

  logic       nop_w, rd_w, mrr_w, blk_w, any_w;
  logic [4:0] busy_q;

  // Command decode and blocking states
  assign mrr_w = i_cmd.cke && !i_cmd.cs_n && i_cmd.ca == CA_MRR;
  assign rd_w  = mrr_w || (i_cmd.cke && !i_cmd.cs_n && i_cmd.ca[2:0] == CA_READ);
  assign nop_w = i_cmd.cke && (i_cmd.cs_n || i_cmd.ca[2:0] == CA_NOP);
  assign blk_w = i_self_refresh || i_deep_pd || i_ca_training;
  assign any_w = o_term_dq_en || o_term_dqs_en || o_term_dm_en;

  // Cycles since the last read or MRR, 0 when idle
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      busy_q <= 5'h0;
    else if (rd_w)
      busy_q <= 5'h1;
    else if (busy_q != 5'h0 && busy_q != READ_BUSY_CYC)
      busy_q <= busy_q + 5'h1;
    else
      busy_q <= 5'h0;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_nop_decode: assert property (i_rst_n |=> o_nop == $past(nop_w))
    else $error("no-op pulse does not follow command");
  a_busy_window: assert property (o_read_busy == $past(busy_q != 5'h0))
    else $error("read window length wrong");
  a_mrr_answer: assert property (mrr_w |=> o_mrr_valid && o_mrr_data[7:3] == 5'h0)
    else $error("mode register read answer missing");
  a_state_off: assert property (blk_w [*2] |-> !any_w)
    else $error("termination on in blocking state");
  a_pin_gates: assert property (!i_term_pin |-> !any_w)
    else $error("termination on with pin low");
  a_lines_equal: assert property (o_term_dq_en == o_term_dqs_en && o_term_dq_en == o_term_dm_en)
    else $error("termination lines disagree");
  a_read_off: assert property (busy_q != 5'h0 |-> !any_w)
    else $error("termination on during read");
  a_rtt_zero: assert property (o_term_rtt_sel == 2'h0 && $past(o_term_rtt_sel) == 2'h0 |-> !any_w)
    else $error("termination on with mode zero");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response late");

  c_read: cover property (rd_w ##1 o_read_busy);
  c_irq: cover property ($rose(o_irq));
  c_term: cover property ($rose(o_term_dq_en));
endmodule

bind dnto_core dnto_core_assertions #(.P_TSI_CYC(P_TSI_CYC), .P_HAS_ODT(P_HAS_ODT)) u_chk (.*);

`default_nettype wire

// ==== tb/dnto_core_tb.sv ====
// Self-checking bench: registers, command decode, temperature status and termination gating.
// Assumes the controller model drives command and termination pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", n, e, g); end end

module dnto_core_tb;
  import dnto_pkg::*;

  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_term_pin, odt = 1'b0;
  dnto_cmd_s   i_cmd;
  logic [7:0]  i_mr_addr, i_awaddr = '0, i_araddr = '0, ad = '0, em, o_mrr_data, r = 8'h38;
  logic [2:0]  i_sensor_code = '0, op = '0;
  logic [3:0]  i_wstrb = 4'hF, st = '0;
  logic [31:0] i_wdata = '0, o_rdata;
  logic [33:0] er;
  logic [1:0]  o_term_rtt_sel, o_bresp, o_rresp, eb;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic        o_nop, o_read_busy, o_mrr_valid, o_term_dq_en, o_term_dqs_en, o_term_dm_en, o_irq;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire         i_self_refresh, i_power_down, i_deep_pd, i_ca_training;
  int          err_total = 0, check_count = 0;
  logic [7:0]  mq[$];
  logic [33:0] rq[$];
  logic [1:0]  bq[$];

  assign {i_ca_training, i_deep_pd, i_self_refresh, i_power_down} = st;

  dnto_core #(.P_TSI_CYC(50), .P_HAS_ODT(1'b1)) dut (.*);
  dnto_ctrl_model u_ctl (.i_clk(i_ref_clk), .i_op(op), .i_addr(ad), .i_odt(odt),
                         .o_cmd(i_cmd), .o_mr_addr(i_mr_addr), .o_term_pin(i_term_pin));

  // 50 MHz clock
  initial
  begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic give_verdict;
    err_total += rq.size() + bq.size() + mq.size(); // Unanswered notes count as misses
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One write; response checked by the monitor
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    int n;
    n = 0;
    bq.push_back(rs);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      @(posedge i_ref_clk);
      if (i_awvalid && o_awready)
        i_awvalid <= 1'b0;
      if (i_wvalid && o_wready)
        i_wvalid <= 1'b0;
    end while (!o_bvalid && ++n < 99);
    i_bready <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  // One read; {resp, data} checked by the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    int n;
    n = 0;
    rq.push_back(x);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
    begin
      @(posedge i_ref_clk);
      if (i_arvalid && o_arready)
        i_arvalid <= 1'b0;
    end while (!o_rvalid && ++n < 99);
    i_rready <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic cmd(input logic [2:0] o, input logic [7:0] a);
    op <= o;
    ad <= a;
    @(posedge i_ref_clk);
  endtask

  // Results compared against the oldest note
  always @(posedge i_ref_clk)
  begin
    if (o_rvalid && i_rready)
    begin
      er = rq.pop_front();
      `CHK("rdata", er, {o_rresp, o_rdata})
    end
    if (o_bvalid && i_bready)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, o_bresp)
    end
    if (o_mrr_valid)
    begin
      em = mq.pop_front();
      `CHK("mrr", em, o_mrr_data)
    end
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    rd(REG_TERM_MODE, 34'h0);
    rd(REG_IRQ_ENABLE, 34'h0);
    rd(REG_IRQ_CLEAR, 34'h0);
    rd(8'h1C, {AXI_SLVERR, 32'h0});
    wr(8'h1C, 32'hF, AXI_SLVERR);
    odt <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(REG_TERM_MODE, m, AXI_OKAY);
      rd(REG_TERM_MODE, {AXI_OKAY, m[31:0]});
      `CHK("rtt", m[1:0], o_term_rtt_sel)
      `CHK("term_on", m != 0, o_term_dqs_en)
    end
    // Pin acts within the cycle
    odt <= 1'b0;
    #2;
    `CHK("pin_off", 1'b0, o_term_dm_en)
    @(posedge i_ref_clk);
    odt <= 1'b1;
    #2;
    `CHK("pin_on", 3'h7, {o_term_dq_en, o_term_dqs_en, o_term_dm_en})
    for (int s = 0; s < 4; s++)
    begin
      @(posedge i_ref_clk);
      st <= 4'h1 << s;
      r = nx(r);
      i_sensor_code <= r[2:0];
      repeat (3) @(posedge i_ref_clk);
      `CHK("state_off", 1'b0, o_term_dq_en)
      st <= 4'h0;
      repeat (3) @(posedge i_ref_clk);
      `CHK("state_on", 1'b1, o_term_dq_en)
      rd(REG_TEMP_STAT, {AXI_OKAY, 29'h0, r[2:0]});
    end
    wr(REG_TERM_MODE, 32'h7, AXI_OKAY);
    // Write with the low strobe off leaves the mode alone
    i_wstrb <= 4'h0;
    wr(REG_TERM_MODE, 32'h0, AXI_OKAY);
    i_wstrb <= 4'hF;
    rd(REG_TERM_MODE, {AXI_OKAY, 32'h7});
    st <= 4'h1;
    repeat (3) @(posedge i_ref_clk);
    `CHK("pd_keep", 1'b1, o_term_dq_en)
    st <= 4'h0;
    i_sensor_code <= TEMP_ELEVATED;
    repeat (3) @(posedge i_ref_clk);
    rd(REG_TEMP_STAT, {AXI_OKAY, 29'h0, TEMP_ELEVATED});
    mq.push_back({5'h0, TEMP_ELEVATED});
    cmd(3'h3, MR_ADDR_TEMP);
    mq.push_back(8'h07);
    cmd(3'h3, MR_ADDR_TERM);
    mq.push_back(8'h00);
    cmd(3'h3, 8'h22);
    cmd(3'h2, 8'h00);
    repeat (3) cmd(3'h1, 8'h00);
    cmd(3'h0, 8'h00);
    `CHK("busy", 1'b1, o_read_busy)
    `CHK("rd_off", 1'b0, o_term_dq_en)
    repeat (20) @(posedge i_ref_clk);
    `CHK("rd_on", 1'b1, o_term_dq_en)
    // Interrupt from a faulty no-op: raise, mask, clear
    wr(REG_IRQ_CLEAR, 32'hF, AXI_OKAY);
    wr(REG_IRQ_ENABLE, 32'h1, AXI_OKAY);
    `CHK("irq_idle", 1'b0, o_irq)
    cmd(3'h4, 8'h00);
    cmd(3'h0, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    `CHK("irq_set", 1'b1, o_irq)
    wr(REG_IRQ_ENABLE, 32'h0, AXI_OKAY);
    `CHK("irq_mask", 1'b0, o_irq)
    wr(REG_IRQ_ENABLE, 32'h1, AXI_OKAY);
    `CHK("irq_unmask", 1'b1, o_irq)
    wr(REG_IRQ_CLEAR, 32'h1, AXI_OKAY);
    `CHK("irq_clr", 1'b0, o_irq)
    // Only the refresh event enabled, cleared, then it must come back
    wr(REG_IRQ_ENABLE, 32'h2, AXI_OKAY);
    wr(REG_IRQ_CLEAR, 32'h2, AXI_OKAY);
    repeat (55) @(posedge i_ref_clk);
    `CHK("tsi", 1'b1, o_irq)
    give_verdict;
  end

  // Watchdog against a hang
  initial
  begin
    #100000;
    err_total++;
    give_verdict;
  end
endmodule

`default_nettype wire

// ==== tb/dnto_ctrl_model.sv ====
// Memory controller model driving command, mode register address and termination pins.
// Assumes the bench requests one command per cycle on i_op.
`timescale 1ns/1ps
`default_nettype none

module dnto_ctrl_model (
  input  wire logic               i_clk,
  input  wire logic [2:0]         i_op,
  input  wire logic [7:0]         i_addr,
  input  wire logic               i_odt,
  output var dnto_pkg::dnto_cmd_s o_cmd,
  output var logic [7:0]          o_mr_addr,
  output logic                    o_term_pin
);
  import dnto_pkg::*;

  // Idle as deselect with clock enable high
  initial
  begin
    o_cmd = '{cke: 1'b1, cs_n: 1'b1, ca: 4'h0};
    o_mr_addr = 8'h00;
  end

  // Ops: 0 deselect, 1 no-op, 2 read, 3 MRR, 4 faulty no-op
  always @(posedge i_clk)
  begin
    o_cmd.cke <= (i_op != 3'h4);
    o_cmd.cs_n <= (i_op == 3'h0);
    o_cmd.ca <= (i_op == 3'h2) ? {1'b0, CA_READ} : (i_op == 3'h3) ? CA_MRR : {~o_cmd.ca[3], CA_NOP};
    o_mr_addr <= (i_op == 3'h3) ? i_addr : ~o_mr_addr; // Unqualified address keeps moving
  end

  // Pin level straight from the request
  assign o_term_pin = i_odt;
endmodule

`default_nettype wire
